// ### hdl/uarx_defines.svh
`ifndef UARX_DEFINES_SVH
`define UARX_DEFINES_SVH

`define UARX_ADDR_W        8
`define UARX_OFF_DATA      8'h00
`define UARX_OFF_CSA       8'h04
`define UARX_OFF_CSB       8'h08
`define UARX_OFF_SHARED    8'h0C
`define UARX_OFF_BAUDL     8'h10

`define UARX_RESP_OKAY     2'h0
`define UARX_RESP_SLVERR   2'h2

`define UARX_CSA_RXC       7
`define UARX_CSA_FE        4
`define UARX_CSA_DOR       3
`define UARX_CSA_PE        2
`define UARX_CSA_DBL       1
`define UARX_CSA_MPF       0
`define UARX_CSB_RXEN      4
`define UARX_CSB_CSZ2      2
`define UARX_CSB_RX9       1
`define UARX_SHR_SEL       7
`define UARX_FC_PAR_HI     5
`define UARX_FC_PAR_LO     4
`define UARX_FC_TWO_STOP   3
`define UARX_FC_CSZ_HI     2
`define UARX_FC_CSZ_LO     1

`define UARX_RST_CSZ       3'h3
`define UARX_RST_BAUD      12'h000
`define UARX_RST_PAR       2'h0

`define UARX_SPB_NORM      5'h10
`define UARX_SPB_DBL       5'h08
`define UARX_VOTE_NORM     5'h08
`define UARX_VOTE_DBL      5'h04
`define UARX_NINE_BITS     4'h9

`define UARX_FIFO_DEPTH    2'h2

`endif

// ### hdl/uarx_pkg.sv
package uarx_pkg;
`include "uarx_defines.svh"

	typedef enum logic [1:0] {
		st_idle  = 2'b00,
		st_start = 2'b01,
		st_bits  = 2'b10
	} uarx_state_t;

	typedef struct packed {
		logic       pe;
		logic       fe;
		logic [8:0] data;
	} uarx_entry_t;

	function automatic logic uarx_maj3(input logic a, input logic b, input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction

	function automatic logic [3:0] uarx_data_bits(input logic [2:0] csz);
		case (csz)
			3'h0: return 4'h5;
			3'h1: return 4'h6;
			3'h2: return 4'h7;
			3'h7: return `UARX_NINE_BITS;
			default: return 4'h8;
		endcase
	endfunction

	function automatic logic uarx_mapped(input logic [`UARX_ADDR_W-1:0] addr);
		return (addr == `UARX_OFF_DATA) || (addr == `UARX_OFF_CSA) ||
			(addr == `UARX_OFF_CSB) || (addr == `UARX_OFF_SHARED) ||
			(addr == `UARX_OFF_BAUDL);
	endfunction

endpackage

// ### hdl/uarx_fifo_if.sv
`timescale 1ns/1ps
interface uarx_fifo_if;
	import uarx_pkg::*;
	logic        push;
	logic        pop;
	logic        flush;
	logic        full;
	logic        empty;
	uarx_entry_t push_entry;
	uarx_entry_t head;

	modport writer (output push, output pop, output flush, output push_entry,
		input full, input empty, input head);
	modport store (input push, input pop, input flush, input push_entry,
		output full, output empty, output head);
endinterface

// ### hdl/uarx_fifo.sv
`timescale 1ns/1ps
module uarx_fifo (
	// system
	input  wire logic   clock,
	input  wire logic   sys_rst,
	// buffer port
	uarx_fifo_if.store  bus
);
	import uarx_pkg::*;

	uarx_entry_t mem [2];
	logic        wr_ptr_ff;
	logic        rd_ptr_ff;
	logic [1:0]  cnt_ff;
	logic [1:0]  nxt_cnt;
	wire         do_push;
	wire         do_pop;

	// two-entry queue, error bits travel with their character
	assign do_push   = bus.push & ~bus.flush & (cnt_ff != `UARX_FIFO_DEPTH);
	assign do_pop    = bus.pop & ~bus.flush & (cnt_ff != 2'h0);
	assign nxt_cnt   = bus.flush ? 2'h0 : (cnt_ff + {1'b0, do_push} - {1'b0, do_pop});
	assign bus.full  = (cnt_ff == `UARX_FIFO_DEPTH);
	assign bus.empty = (cnt_ff == 2'h0);
	assign bus.head  = mem[rd_ptr_ff];

	always_ff @(posedge clock) begin
		if (sys_rst || bus.flush) begin
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			cnt_ff    <= 2'h0;
		end else begin
			wr_ptr_ff <= wr_ptr_ff ^ do_push;
			rd_ptr_ff <= rd_ptr_ff ^ do_pop;
			cnt_ff    <= nxt_cnt;
		end
	end

	// data storage needs no reset; empty gates every use of it
	always_ff @(posedge clock) begin
		if (do_push) begin
			mem[wr_ptr_ff] <= bus.push_entry;
		end
	end
endmodule

// ### hdl/uarx_top.sv
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "uarx_defines.svh"
module uarx_top (
	// system
	input  wire logic                    clock,
	input  wire logic                    sys_rst,
	// serial line
	input  wire logic                    rx_serial_in,
	// axi4-lite write address
	input  wire logic [`UARX_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	// axi4-lite read address
	input  wire logic [`UARX_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	// settings shared with the transmitter
	output logic [2:0]                   char_size_field,
	output logic                         two_stop_select,
	output logic                         double_speed_select,
	output logic                         sample_tick
);
	import uarx_pkg::*;

	// bus slave state
	logic                    awready_ff;
	logic                    aw_full_ff;
	logic [`UARX_ADDR_W-1:0] awaddr_ff;
	logic                    wready_ff;
	logic                    w_full_ff;
	logic [7:0]              wdata_ff;
	logic                    wstrb0_ff;
	logic                    bvalid_ff;
	logic [1:0]              bresp_ff;
	logic                    arready_ff;
	logic                    rvalid_ff;
	logic [31:0]             rdata_ff;
	logic [1:0]              rresp_ff;
	logic                    shr_rd_ff;

	// configuration and status
	logic                    dbl_ff;
	logic                    mpf_ff;
	logic                    rxen_ff;
	logic [2:0]              csz_ff;
	logic                    two_stop_ff;
	logic [1:0]              par_mode_ff;
	logic [11:0]             baud_ff;
	logic                    dor_ff;

	// receiver state
	logic                    sync1_ff;
	logic                    sync2_ff;
	logic                    sync3_ff;
	logic                    level_ff;
	logic                    prev_ff;
	logic                    tick_ff;
	logic [11:0]             div_cnt_ff;
	uarx_state_t             state_ff;
	logic [4:0]              samp_ff;
	logic [3:0]              bit_ff;
	logic [1:0]              votes_ff;
	logic [8:0]              shift_ff;
	logic                    par_acc_ff;
	logic                    pe_ff;

	// next values
	uarx_state_t             nxt_state;
	logic [4:0]              nxt_samp;
	logic [3:0]              nxt_bit;
	logic [8:0]              nxt_shift;
	logic                    nxt_par_acc;
	logic                    nxt_pe;
	logic                    frame_done;
	wire                     nxt_aw_full;
	wire                     nxt_w_full;
	wire                     nxt_bvalid;
	wire                     nxt_rvalid;
	wire                     nxt_shr_rd;
	wire                     nxt_dor;
	wire                     nxt_level;

	uarx_fifo_if fifo_bus ();

	uarx_fifo u_fifo (
		.clock   (clock),
		.sys_rst (sys_rst),
		.bus     (fifo_bus.store)
	);

	// write path decode
	wire aw_take     = s_axi_awvalid & awready_ff;
	wire w_take      = s_axi_wvalid & wready_ff;
	wire wr_go       = aw_full_ff & w_full_ff & ~bvalid_ff;
	wire wr_en       = wr_go & wstrb0_ff;
	wire wr_csa      = wr_en & (awaddr_ff == `UARX_OFF_CSA);
	wire wr_csb      = wr_en & (awaddr_ff == `UARX_OFF_CSB);
	wire wr_shr      = wr_en & (awaddr_ff == `UARX_OFF_SHARED);
	wire wr_baudl    = wr_en & (awaddr_ff == `UARX_OFF_BAUDL);
	wire wr_fc       = wr_shr & wdata_ff[`UARX_SHR_SEL];
	wire wr_bh       = wr_shr & ~wdata_ff[`UARX_SHR_SEL];
	wire [1:0] wresp = uarx_mapped(awaddr_ff) ? `UARX_RESP_OKAY : `UARX_RESP_SLVERR;

	assign nxt_aw_full = aw_take | (aw_full_ff & ~wr_go);
	assign nxt_w_full  = w_take | (w_full_ff & ~wr_go);
	assign nxt_bvalid  = wr_go | (bvalid_ff & ~s_axi_bready);

	// read path decode
	wire rd_go       = s_axi_arvalid & arready_ff;
	wire rd_data     = rd_go & (s_axi_araddr == `UARX_OFF_DATA);
	wire rd_shr      = rd_go & (s_axi_araddr == `UARX_OFF_SHARED);
	wire [1:0] rresp = uarx_mapped(s_axi_araddr) ? `UARX_RESP_OKAY : `UARX_RESP_SLVERR;
	wire rx_complete_flag         = ~fifo_bus.empty;
	uarx_entry_t head;
	assign head      = fifo_bus.head;

	wire [7:0] csa_val = {rx_complete_flag, 2'b00, head.fe & rx_complete_flag, dor_ff, head.pe & rx_complete_flag, dbl_ff, mpf_ff};
	wire [7:0] csb_val = {3'b000, rxen_ff, 1'b0, csz_ff[2], head.data[8] & rx_complete_flag, 1'b0};
	wire [7:0] fc_val  = {1'b1, 1'b0, par_mode_ff, two_stop_ff, csz_ff[1:0], 1'b0};
	wire [7:0] bh_val  = {4'h0, baud_ff[11:8]};
	wire [7:0] dat_val = rx_complete_flag ? head.data[7:0] : 8'h00;
	// frame control only right after a read of the same location
	wire [7:0] shr_val = shr_rd_ff ? fc_val : bh_val;
	wire [7:0] rd_byte =
		(s_axi_araddr == `UARX_OFF_DATA)   ? dat_val :
		(s_axi_araddr == `UARX_OFF_CSA)    ? csa_val :
		(s_axi_araddr == `UARX_OFF_CSB)    ? csb_val :
		(s_axi_araddr == `UARX_OFF_SHARED) ? shr_val :
		(s_axi_araddr == `UARX_OFF_BAUDL)  ? baud_ff[7:0] : 8'h00;

	assign nxt_rvalid = rd_go | (rvalid_ff & ~s_axi_rready);
	// any other access in between breaks the timed sequence
	assign nxt_shr_rd = rd_go ? rd_shr : (wr_go ? 1'b0 : shr_rd_ff);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			awready_ff <= 1'b0;
			aw_full_ff <= 1'b0;
			wready_ff  <= 1'b0;
			w_full_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= `UARX_RESP_OKAY;
		end else begin
			awready_ff <= ~nxt_aw_full;
			aw_full_ff <= nxt_aw_full;
			wready_ff  <= ~nxt_w_full;
			w_full_ff  <= nxt_w_full;
			bvalid_ff  <= nxt_bvalid;
			bresp_ff   <= wr_go ? wresp : bresp_ff;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			awaddr_ff <= '0;
			wdata_ff  <= 8'h00;
			wstrb0_ff <= 1'b0;
		end else begin
			awaddr_ff <= aw_take ? s_axi_awaddr : awaddr_ff;
			wdata_ff  <= w_take ? s_axi_wdata[7:0] : wdata_ff;
			wstrb0_ff <= w_take ? s_axi_wstrb[0] : wstrb0_ff;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= `UARX_RESP_OKAY;
			shr_rd_ff  <= 1'b0;
		end else begin
			arready_ff <= ~nxt_rvalid;
			rvalid_ff  <= nxt_rvalid;
			rdata_ff   <= rd_go ? {24'h00_0000, rd_byte} : rdata_ff;
			rresp_ff   <= rd_go ? rresp : rresp_ff;
			shr_rd_ff  <= nxt_shr_rd;
		end
	end

	// control registers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			dbl_ff      <= 1'b0;
			mpf_ff      <= 1'b0;
			rxen_ff     <= 1'b0;
			csz_ff      <= `UARX_RST_CSZ;
			two_stop_ff <= 1'b0;
			par_mode_ff <= `UARX_RST_PAR;
			baud_ff     <= `UARX_RST_BAUD;
		end else begin
			if (wr_csa) begin
				dbl_ff <= wdata_ff[`UARX_CSA_DBL];
				mpf_ff <= wdata_ff[`UARX_CSA_MPF];
			end
			if (wr_csb) begin
				rxen_ff   <= wdata_ff[`UARX_CSB_RXEN];
				csz_ff[2] <= wdata_ff[`UARX_CSB_CSZ2];
			end
			// select bit steers the shared write
			if (wr_fc) begin
				par_mode_ff <= wdata_ff[`UARX_FC_PAR_HI:`UARX_FC_PAR_LO];
				two_stop_ff <= wdata_ff[`UARX_FC_TWO_STOP];
				csz_ff[1:0] <= wdata_ff[`UARX_FC_CSZ_HI:`UARX_FC_CSZ_LO];
			end
			if (wr_bh) begin
				baud_ff[11:8] <= wdata_ff[3:0];
			end
			if (wr_baudl) begin
				baud_ff[7:0] <= wdata_ff;
			end
		end
	end

	// one size setting feeds both directions
	assign char_size_field     = csz_ff;
	assign two_stop_select     = two_stop_ff;
	assign double_speed_select = dbl_ff;
	assign sample_tick         = tick_ff;

	// sample clock: one tick every divisor+1 cycles, 16x or 8x baud
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			div_cnt_ff <= 12'h000;
			tick_ff    <= 1'b0;
		end else begin
			div_cnt_ff <= (div_cnt_ff == 12'h000) ? baud_ff : (div_cnt_ff - 12'h001);
			tick_ff    <= (div_cnt_ff == 12'h000);
		end
	end

	// three-stage pin synchroniser, change taken when stages two and three agree
	assign nxt_level = (sync2_ff == sync3_ff) ? sync3_ff : level_ff;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
			sync3_ff <= 1'b1;
			level_ff <= 1'b1;
			prev_ff  <= 1'b1;
		end else begin
			sync1_ff <= rx_serial_in;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			level_ff <= nxt_level;
			prev_ff  <= tick_ff ? level_ff : prev_ff;
		end
	end

	// bit timing
	wire [4:0] spb     = dbl_ff ? `UARX_SPB_DBL : `UARX_SPB_NORM;
	wire [4:0] vfirst  = dbl_ff ? `UARX_VOTE_DBL : `UARX_VOTE_NORM;
	wire       at_v0   = (samp_ff == vfirst);
	wire       at_v1   = (samp_ff == vfirst + 5'h01);
	wire       at_dec  = (samp_ff == vfirst + 5'h02);
	wire [4:0] samp_up = (samp_ff == spb) ? 5'h01 : (samp_ff + 5'h01);
	// two of three centre samples decide the bit
	wire       vote    = uarx_maj3(votes_ff[1], votes_ff[0], level_ff);

	// frame layout
	wire [3:0] nbits    = uarx_data_bits(csz_ff);
	wire       par_en   = par_mode_ff[1];
	wire [3:0] stop_pos = nbits + {3'b000, par_en};
	wire       is_data  = (bit_ff < nbits);
	wire       is_par   = par_en & (bit_ff == nbits);
	wire       is_stop  = (bit_ff == stop_pos);

	always_comb begin
		nxt_state   = state_ff;
		nxt_samp    = samp_ff;
		nxt_bit     = bit_ff;
		nxt_shift   = shift_ff;
		nxt_par_acc = par_acc_ff;
		nxt_pe      = pe_ff;
		frame_done  = 1'b0;
		if (!rxen_ff) begin
			nxt_state = st_idle;
		end else if (tick_ff) begin
			case (state_ff)
				st_idle: begin
					// high to low on the sample grid; this low is sample one
					if (prev_ff && !level_ff) begin
						nxt_state = st_start;
						nxt_samp  = 5'h01;
					end
				end
				st_start: begin
					nxt_samp = samp_up;
					// start check on the centre window
					if (at_dec) begin
						nxt_bit     = 4'h0;
						nxt_shift   = 9'h000;
						nxt_par_acc = 1'b0;
						nxt_pe      = 1'b0;
						// mostly high means a spike, wait for the next edge
						nxt_state   = vote ? st_idle : st_bits;
					end
				end
				st_bits: begin
					nxt_samp = samp_up;
					if (at_dec) begin
						nxt_bit = bit_ff + 4'h1;
						if (is_stop) begin
							// only the first stop bit is used
							frame_done = 1'b1;
							// idle right after the last vote sample
							nxt_state  = st_idle;
						end else if (is_data) begin
							nxt_shift[bit_ff] = vote;
							nxt_par_acc       = par_acc_ff ^ vote;
						end else if (is_par) begin
							nxt_pe = vote ^ par_acc_ff ^ par_mode_ff[0];
						end
					end
				end
				default: begin
					nxt_state = st_idle;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_ff   <= st_idle;
			samp_ff    <= 5'h00;
			bit_ff     <= 4'h0;
			shift_ff   <= 9'h000;
			par_acc_ff <= 1'b0;
			pe_ff      <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			samp_ff    <= nxt_samp;
			bit_ff     <= nxt_bit;
			shift_ff   <= nxt_shift;
			par_acc_ff <= nxt_par_acc;
			pe_ff      <= nxt_pe;
		end
	end

	// first two window samples held for the vote
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			votes_ff <= 2'b11;
		end else if (tick_ff && (at_v0 || at_v1)) begin
			votes_ff <= {votes_ff[0], level_ff};
		end
	end

	// frame type: ninth bit for nine-bit frames, else first stop bit
	wire frame_type = (nbits == `UARX_NINE_BITS) ? shift_ff[8] : vote;
	// type one is an address and always passes the filter
	wire keep_frame = ~mpf_ff | frame_type;
	// data frames dropped while filtering
	wire want_push  = frame_done & keep_frame;
	// overrun is flagged at completion, the character itself is lost
	wire ovr_evt    = want_push & fifo_bus.full;

	assign fifo_bus.push            = want_push & ~fifo_bus.full;
	assign fifo_bus.push_entry.pe   = pe_ff;
	// zero stop bit marks frame error
	assign fifo_bus.push_entry.fe   = ~vote;
	assign fifo_bus.push_entry.data = shift_ff;
	// reading the data location advances the queue
	assign fifo_bus.pop             = rd_data;
	// disabling the receiver empties the queue
	assign fifo_bus.flush           = ~rxen_ff;

	// set wins over the clear by a data read
	assign nxt_dor = ovr_evt | (dor_ff & ~rd_data & rxen_ff);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			dor_ff <= 1'b0;
		end else begin
			dor_ff <= nxt_dor;
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
endmodule

// ### bench/uarx_checker.sv
`timescale 1ns/1ps
`include "uarx_defines.svh"
module uarx_checker (
	// system
	input wire logic                    clock,
	input wire logic                    sys_rst,
	// register bus
	input wire logic [`UARX_ADDR_W-1:0] s_axi_awaddr,
	input wire logic                    s_axi_awvalid,
	input wire logic                    s_axi_awready,
	input wire logic [31:0]             s_axi_wdata,
	input wire logic [3:0]              s_axi_wstrb,
	input wire logic                    s_axi_wvalid,
	input wire logic                    s_axi_wready,
	input wire logic [1:0]              s_axi_bresp,
	input wire logic                    s_axi_bvalid,
	input wire logic                    s_axi_bready,
	input wire logic [`UARX_ADDR_W-1:0] s_axi_araddr,
	input wire logic                    s_axi_arvalid,
	input wire logic                    s_axi_arready,
	input wire logic [31:0]             s_axi_rdata,
	input wire logic [1:0]              s_axi_rresp,
	input wire logic                    s_axi_rvalid,
	input wire logic                    s_axi_rready,
	// settings
	input wire logic [2:0]              char_size_field,
	input wire logic                    two_stop_select,
	input wire logic                    double_speed_select
);
	import uarx_pkg::*;
	logic [`UARX_ADDR_W-1:0] aw_ff;
	logic [8:0]              wd_ff;
	logic                    shr_ff;
	wire aw_go = s_axi_awvalid && s_axi_awready;
	wire ar_go = s_axi_arvalid && s_axi_arready;
	wire shr_a = s_axi_araddr == `UARX_OFF_SHARED;
	// write lands on the edge where bvalid rises, so latch its operands
	always_ff @(posedge clock) begin
		if (aw_go) aw_ff <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) wd_ff <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
		if (sys_rst || aw_go) shr_ff <= 1'b0;
		else if (ar_go) shr_ff <= shr_a;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence s_ar_taken;
		ar_go;
	endsequence
	sequence s_wr_done;
		$rose(s_axi_bvalid) && s_axi_bresp == `UARX_RESP_OKAY && wd_ff[8];
	endsequence
	property p_rd_answer;
		s_ar_taken |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0;
	endproperty
	property p_rd_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_fc_write;
		s_wr_done and (aw_ff == `UARX_OFF_SHARED && wd_ff[7]) |->
			char_size_field[1:0] == wd_ff[2:1] && two_stop_select == wd_ff[3];
	endproperty
	property p_divh_write;
		s_wr_done and (aw_ff == `UARX_OFF_SHARED && !wd_ff[7]) |->
			$stable(char_size_field) && $stable(two_stop_select);
	endproperty
	property p_dbl_write;
		s_wr_done and (aw_ff == `UARX_OFF_CSA) |-> double_speed_select == wd_ff[1];
	endproperty
	property p_csz_msb;
		s_wr_done and (aw_ff == `UARX_OFF_CSB) |-> char_size_field[2] == wd_ff[2];
	endproperty
	property p_shr_first;
		s_ar_taken and shr_a && !shr_ff |=> s_axi_rdata[7] == 1'b0;
	endproperty
	property p_shr_second;
		s_ar_taken and shr_a && shr_ff |=> s_axi_rdata[7:6] == 2'h2 &&
			s_axi_rdata[3:0] == {two_stop_select, char_size_field[1:0], 1'b0};
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late or wide");
	a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
	a_b_hold: assert property (p_b_hold) else $error("write response not held");
	a_fc_write: assert property (p_fc_write) else $error("frame control not written");
	a_divh_write: assert property (p_divh_write) else $error("frame control changed");
	a_dbl_write: assert property (p_dbl_write) else $error("double speed not written");
	a_csz_msb: assert property (p_csz_msb) else $error("char size msb wrong");
	a_shr_first: assert property (p_shr_first) else $error("first shared read wrong");
	a_shr_second: assert property (p_shr_second) else $error("second shared read wrong");
endmodule
bind uarx_top uarx_checker u_uarx_checker (
	.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .char_size_field, .two_stop_select, .double_speed_select
);

// ### bench/uarx_serial_source.sv
`timescale 1ns/1ps
module uarx_serial_source (
	// system
	input wire logic clock,
	// serial line toward the receiver
	output logic     line
);
	initial line = 1'b1;
	// exact bit rate keeps the sender well inside the tolerance
	task automatic send(input logic [8:0] bits, input int nb, input logic stp,
		input int bc, input int sc);
		@(posedge clock);
		line <= 1'b0;
		repeat (bc) @(posedge clock);
		for (int i = 0; i < nb; i++) begin
			line <= bits[i];  // ninth bit marks address frames
			repeat (bc) @(posedge clock);
		end
		line <= stp;  // frame type in first stop, idle high after it
		repeat (sc) @(posedge clock);
		line <= 1'b1;
	endtask
	task automatic glitch(input int n);
		@(posedge clock);
		line <= 1'b0;
		repeat (n) @(posedge clock);
		line <= 1'b1;
	endtask
endmodule

// ### bench/uart_async_receiver_recovery_test.sv
`timescale 1ns/1ps
`include "uarx_defines.svh"
module uart_async_receiver_recovery_test;
	import uarx_pkg::*;
	logic clock = 1'b0, sys_rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, rnd = 32'hD7EC107F;
	wire logic rx_serial_in, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire logic s_axi_rvalid, two_stop_select, double_speed_select, sample_tick;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [2:0] char_size_field;
	int miscompares = 0, tests_run = 0, cycles = 0;
	always #2.5 clock = ~clock;
	uarx_top u_uarx_top (.clock, .sys_rst, .rx_serial_in, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.char_size_field, .two_stop_select, .double_speed_select, .sample_tick);
	uarx_serial_source u_uarx_serial_source (.clock, .line(rx_serial_in));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] csa(input logic rx_complete_flag, fe, dbl, mpf);
		return {24'h0, rx_complete_flag, 2'h0, fe, 2'h0, dbl, mpf};
	endfunction
	// only the five low word offsets are mapped
	function automatic logic [1:0] resp(input logic [7:0] a);
		return (a > `UARX_OFF_BAUDL) ? `UARX_RESP_SLVERR : `UARX_RESP_OKAY;
	endfunction
	task automatic results;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// ready is looked at on the falling edge, acted on at the next rising one
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic aw, w, b;
		logic [1:0] rs;
		@(posedge clock);
		{s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		b = 1'b0;
		while (!b) begin
			@(negedge clock);
			{aw, w, b, rs} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
			@(posedge clock);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		chk({30'h0, rs}, {30'h0, resp(a)});
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic ar, r;
		logic [1:0] rs;
		logic [31:0] v;
		@(posedge clock);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		r = 1'b0;
		while (!r) begin
			@(negedge clock);
			{ar, r, v, rs} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge clock);
			if (ar) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		chk(v, exp);
		chk({30'h0, rs}, {30'h0, resp(a)});
	endtask
	// second stop bit is the idle high that follows
	task automatic rx(input logic [8:0] b, input int nb, input logic stp, input int bc);
		u_uarx_serial_source.send(b, nb, stp, bc, bc);
		repeat (bc + 12) @(posedge clock);
	endtask
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			results();
		end
	end
	initial begin
		logic [8:0] b;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		rdc(`UARX_OFF_CSA, csa(0, 0, 0, 0));
		rdc(`UARX_OFF_SHARED, 32'h0);
		rdc(`UARX_OFF_SHARED, 32'h86);
		wr(`UARX_OFF_SHARED, 8'h02);
		rdc(`UARX_OFF_SHARED, 32'h2);
		rdc(8'h14, 32'h0);
		wr(8'h14, 8'h55);
		wr(`UARX_OFF_SHARED, 8'h00);
		// divisor 0x200 is still counting down in the tick divider; wait it out
		chk({31'h0, sample_tick}, 32'h0);
		wr(`UARX_OFF_CSB, 8'h10);
		repeat (520) @(posedge clock);
		chk({31'h0, sample_tick}, 32'h1);
		$display("test registers done");
		u_uarx_serial_source.glitch(4);
		repeat (40) @(posedge clock);
		rdc(`UARX_OFF_CSA, csa(0, 0, 0, 0));
		for (int i = 0; i < 4; i++) begin
			b = (i < 2) ? {1'b0, {8{i[0]}}} : {1'b0, rnd[7:0]};
			rnd = lfsr(rnd);
			rx(b, 8, 1'b1, 16);
			rdc(`UARX_OFF_CSA, csa(1, 0, 0, 0));
			rdc(`UARX_OFF_DATA, {23'h0, b});
		end
		b = {1'b0, rnd[7:0]};
		rnd = lfsr(rnd);
		u_uarx_serial_source.send(9'h0A5, 8, 1'b1, 16, 11);
		rx(b, 8, 1'b1, 16);
		rdc(`UARX_OFF_DATA, 32'hA5);
		rdc(`UARX_OFF_DATA, {23'h0, b});
		rdc(`UARX_OFF_CSA, csa(0, 0, 0, 0));
		rx(9'h03C, 8, 1'b0, 16);
		rdc(`UARX_OFF_CSA, csa(1, 1, 0, 0));
		rdc(`UARX_OFF_DATA, 32'h3C);
		$display("test normal speed done");
		wr(`UARX_OFF_CSA, 8'h02);
		chk({31'h0, double_speed_select}, 32'h1);
		u_uarx_serial_source.glitch(2);
		repeat (20) @(posedge clock);
		rx({1'b0, rnd[7:0]}, 8, 1'b1, 8);
		rdc(`UARX_OFF_CSA, csa(1, 0, 1, 0));
		rdc(`UARX_OFF_DATA, {24'h0, rnd[7:0]});
		rdc(`UARX_OFF_CSA, csa(0, 0, 1, 0));
		$display("test double speed done");
		wr(`UARX_OFF_CSA, 8'h01);
		rx(9'h011, 8, 1'b0, 16);
		rdc(`UARX_OFF_CSA, csa(0, 0, 0, 1));
		rx(9'h022, 8, 1'b1, 16);
		rdc(`UARX_OFF_CSA, csa(1, 0, 0, 1));
		rdc(`UARX_OFF_DATA, 32'h22);
		wr(`UARX_OFF_SHARED, 8'h86);
		wr(`UARX_OFF_CSB, 8'h14);
		chk({29'h0, char_size_field}, 32'h7);
		rx({1'b0, rnd[7:0]}, 9, 1'b1, 16);
		rdc(`UARX_OFF_CSA, csa(0, 0, 0, 1));
		rx(9'h1C3, 9, 1'b1, 16);
		rdc(`UARX_OFF_CSB, 32'h16);
		rdc(`UARX_OFF_DATA, 32'hC3);
		$display("test multidrop done");
		results();
	end
endmodule
